// File: bench/acr_host.sv
// host processor model: single-byte register reads and writes
// assumes the serial front end is already reduced to one request per cycle
`timescale 1ns/1ps
module acr_host (
  input wire logic mclk,
  output acr_pkg::acr_req_t req,
  input wire logic [7:0] rd_data
);
  // idle bus at time zero
  initial begin
    req = '0;
  end

  // one write strobe, then the released lines carry inverted values
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    req.addr = a;
    req.wdata = d;
    req.wr = 1'b1;
    @(posedge mclk);
    #1;
    req.wr = 1'b0;
    req.addr = ~a;
    req.wdata = ~d;
  endtask : wr

  // one read strobe; data taken a full cycle later so either latency holds
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    #1;
    req.addr = a;
    req.rd = 1'b1;
    @(posedge mclk);
    #1;
    req.rd = 1'b0;
    req.addr = ~a;
    @(posedge mclk);
    #1;
    d = rd_data;
  endtask : rd
endmodule : acr_host

// File: bench/acr_tb.sv
// self-checking bench for the status/control register bank
// assumes acr_regs and the host model; events driven here in the core's place
`timescale 1ns/1ps
module testbench;
  logic mclk = 1'b0; // 10 MHz clock
  logic rst = 1'b1; // sync reset, active high
  acr_pkg::acr_req_t req; // from host model
  acr_pkg::acr_evt_t evt = '0; // core events and buffer levels
  acr_pkg::acr_evt_t p; // scratch event pattern
  logic otp_fail_pin = 1'b0;
  logic vdd_low_pin = 1'b0;
  logic [7:0] rd_data;
  logic i2c_nack;
  acr_pkg::acr_ctrl_t ctrl;
  logic [7:0] d; // scratch read byte
  int error_cnt = 0;
  int n_checks = 0;

  // half period 50 ns
  always #50 mclk = ~mclk;

  // short settle count keeps the low-power wait visible in the run
  acr_regs #(.SETTLE_CYC(20)) acr_regs_inst (.mclk(mclk), .rst(rst), .req(req), .evt(evt),
    .otp_fail_pin(otp_fail_pin), .vdd_low_pin(vdd_low_pin), .rd_data(rd_data),
    .i2c_nack(i2c_nack), .ctrl(ctrl));
  acr_host acr_host_inst (.mclk(mclk), .req(req), .rd_data(rd_data));

  // byte compare
  task chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: byte %h, expected %h", $time, got, exp);
    end
  endtask : chk8

  // single control bit compare
  task chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: bit %b, expected %b", $time, got, exp);
    end
  endtask : chk1

  // read one register and compare
  task rchk(input logic [7:0] a, input logic [7:0] exp);
    acr_host_inst.rd(a, d);
    chk8(d, exp);
  endtask : rchk

  // wait n edges, land just after the last one
  task cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc

  // one-cycle pulse of the pulse fields in e; levels persist
  task ev(input acr_pkg::acr_evt_t e);
    @(posedge mclk);
    #1;
    evt = e;
    @(posedge mclk);
    #1;
    evt.sample_new = 1'b0;
    evt.sleep_evt = 1'b0;
    evt.wake_evt = 1'b0;
    evt.tilt_evt = 1'b0;
    evt.tap_evt = 1'b0;
    evt.buf_full = 1'b0;
    evt.buf_read = 1'b0;
    evt.reboot_done = 1'b0;
    cyc(3);
  endtask : ev

  // always write the other control bits with operate clear, then set operate
  task run_mode(input logic [7:0] c1);
    acr_host_inst.wr(8'h18, c1 & 8'h7f);
    acr_host_inst.wr(8'h18, c1);
  endtask : run_mode

  // reset values and the power-on bit
  task t_reset;
    rchk(8'h18, 8'h00);
    rchk(8'h19, 8'h3f);
    rchk(8'h1a, 8'ha8);
    chk8({ctrl.tilt_rate, ctrl.tap_rate_field, ctrl.motion_rate_field}, 8'ha8);
    rchk(8'h15, 8'h08);
    rchk(8'h15, 8'h00);
    rchk(8'h0c, 8'h55);
    rchk(8'h30, 8'h00);
    $display("test reset done");
  endtask : t_reset

  // range codes, mirrors, running status, low-power settle
  task t_mode;
    for (int r = 0; r < 4; r++) begin
      acr_host_inst.wr(8'h18, 8'(r << 3));
      chk8({6'h00, ctrl.range_select}, 8'(r));
    end
    run_mode(8'hc0);
    rchk(8'h15, 8'hc4);
    vdd_low_pin = 1'b1;
    cyc(6);
    chk1(ctrl.running, 1'b0);
    vdd_low_pin = 1'b0;
    cyc(6);
    run_mode(8'h80);
    cyc(5);
    chk1(ctrl.running, 1'b0);
    cyc(30);
    chk1(ctrl.running, 1'b1);
    rchk(8'h15, 8'h84);
    $display("test mode done");
  endtask : t_mode

  // latched sources, axis report, combined bit, release read
  task t_events;
    run_mode(8'he7);
    chk8({ctrl.operate_enable, ctrl.fine_precision_select, ctrl.new_sample_irq_enable, 2'h0,
      ctrl.tap_engine_enable, ctrl.motion_engine_enable, ctrl.tilt_engine_enable}, 8'he7);
    p = evt;
    p.sleep_evt = 1'b1;
    ev(p);
    p = evt;
    p.wake_evt = 1'b1;
    p.wake_dir = 6'h24;
    p.tilt_evt = 1'b1;
    p.tilt_dir = 6'h08;
    p.tap_evt = 1'b1;
    p.tap_kind = 2'h2;
    p.sample_new = 1'b1;
    ev(p);
    rchk(8'h13, 8'h9b);
    rchk(8'h14, 8'h24);
    chk1(ctrl.irq_any, 1'b1);
    rchk(8'h15, 8'hd5);
    rchk(8'h17, 8'h00);
    rchk(8'h13, 8'h00);
    chk1(ctrl.irq_any, 1'b0);
    for (int k = 1; k < 4; k++) begin
      p = evt;
      p.tap_evt = 1'b1;
      p.tap_kind = 2'(k);
      ev(p);
      rchk(8'h13, 8'(k << 2));
      rchk(8'h17, 8'h00);
    end
    p = evt;
    p.sample_new = 1'b1;
    ev(p);
    rchk(8'h13, 8'h10);
    rchk(8'h06, 8'h00);
    rchk(8'h13, 8'h00);
    $display("test events done");
  endtask : t_events

  // engines off: no engine flags, new sample not an interrupt
  task t_enable;
    // standby with enable bits still set: engines must be gated off
    acr_host_inst.wr(8'h18, 8'h67);
    chk8({ctrl.operate_enable, ctrl.fine_precision_select, ctrl.new_sample_irq_enable, 2'h0,
      ctrl.tap_engine_enable, ctrl.motion_engine_enable, ctrl.tilt_engine_enable}, 8'h60);
    run_mode(8'hc0);
    p = evt;
    p.wake_evt = 1'b1;
    p.wake_dir = 6'h01;
    p.tilt_evt = 1'b1;
    p.tilt_dir = 6'h01;
    p.tap_evt = 1'b1;
    p.tap_kind = 2'h1;
    p.sample_new = 1'b1;
    ev(p);
    rchk(8'h13, 8'h10);
    chk1(ctrl.irq_any, 1'b0);
    rchk(8'h14, 8'h00);
    rchk(8'h17, 8'h00);
    $display("test enable done");
  endtask : t_enable

  // only the unmasked tilt direction latches
  task t_mask;
    acr_host_inst.wr(8'h18, 8'h00);
    acr_host_inst.wr(8'h19, 8'h20);
    run_mode(8'hc1);
    p = evt;
    p.tilt_evt = 1'b1;
    p.tilt_dir = 6'h01;
    ev(p);
    rchk(8'h13, 8'h00);
    p.tilt_dir = 6'h20;
    ev(p);
    rchk(8'h13, 8'h01);
    rchk(8'h17, 8'h00);
    rchk(8'h19, 8'h20);
    $display("test mask done");
  endtask : t_mask

  // buffer full and watermark flags, trigger mode ignored
  task t_buf;
    p = evt;
    p.buf_full = 1'b1;
    ev(p);
    rchk(8'h13, 8'h40);
    p = evt;
    p.buf_read = 1'b1;
    ev(p);
    rchk(8'h13, 8'h00);
    evt.watermark_level = 7'h0a;
    evt.buf_level = 8'h0b;
    cyc(3);
    rchk(8'h13, 8'h20);
    evt.buf_level = 8'h05;
    p = evt;
    p.buf_read = 1'b1;
    ev(p);
    rchk(8'h13, 8'h00);
    evt.buf_mode = 2'h2;
    evt.buf_level = 8'h14;
    cyc(3);
    rchk(8'h13, 8'h00);
    evt.buf_mode = 2'h0;
    evt.buf_level = 8'h00;
    $display("test buffer done");
  endtask : t_buf

  // command test handshake
  task t_ctest;
    acr_host_inst.wr(8'h18, 8'h00);
    acr_host_inst.wr(8'h19, 8'h7f);
    rchk(8'h0c, 8'haa);
    rchk(8'h0c, 8'h55);
    rchk(8'h19, 8'h3f);
    acr_host_inst.wr(8'h1a, 8'h5d);
    rchk(8'h1a, 8'h5d);
    chk8({ctrl.tilt_rate, ctrl.tap_rate_field, ctrl.motion_rate_field}, 8'h5d);
    $display("test command done");
  endtask : t_ctest

  // trim failure, host reboots; nack and ignored writes meanwhile
  task t_reboot;
    otp_fail_pin = 1'b1;
    cyc(6);
    acr_host_inst.rd(8'h15, d);
    chk1(d[5], 1'b1);
    otp_fail_pin = 1'b0;
    // let the synchroniser drain, else the still-high set beats the reboot clear
    cyc(3);
    acr_host_inst.wr(8'h19, 8'hbf);
    cyc(2);
    chk1(i2c_nack, 1'b1);
    chk1(ctrl.reboot_busy, 1'b1);
    acr_host_inst.rd(8'h19, d);
    chk1(d[7], 1'b1);
    acr_host_inst.wr(8'h1a, 8'h00);
    rchk(8'h1a, 8'h5d);
    acr_host_inst.rd(8'h15, d);
    chk1(d[5], 1'b0);
    p = evt;
    p.reboot_done = 1'b1;
    ev(p);
    chk1(i2c_nack, 1'b0);
    chk1(ctrl.reboot_busy, 1'b0);
    rchk(8'h19, 8'h3f);
    rchk(8'h1a, 8'ha8);
    $display("test reboot done");
  endtask : t_reboot

  // counts, verdict, stop
  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test

  // main sequence
  initial begin
    repeat (12) @(posedge mclk);
    #1;
    rst = 1'b0;
    t_reset;
    t_mode;
    t_events;
    t_enable;
    t_mask;
    t_buf;
    t_ctest;
    t_reboot;
    end_of_test;
  end

  // watchdog, far beyond the expected run of under a thousand cycles
  initial begin
    #2000000;
    error_cnt++;
    end_of_test;
  end
endmodule : testbench

// File: rtl/acr_pkg.sv
// constants, field positions and carrier types of the status/control bank
// assumes one 10 MHz clock; host transfers arrive already decoded to bytes
package acr_pkg;
  // register offsets
  localparam logic [7:0] OFS_DATA_FIRST = 8'h06;
  localparam logic [7:0] OFS_DATA_LAST = 8'h0b;
  localparam logic [7:0] OFS_CMD_RESP = 8'h0c;
  localparam logic [7:0] OFS_IRQ_SRC = 8'h13;
  localparam logic [7:0] OFS_AXIS = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h15;
  localparam logic [7:0] OFS_RELEASE = 8'h17;
  localparam logic [7:0] OFS_CTRL1 = 8'h18;
  localparam logic [7:0] OFS_CTRL2 = 8'h19;
  localparam logic [7:0] OFS_CTRL3 = 8'h1a;
  // values after reset and the command test responses
  localparam logic [7:0] RST_CTRL1 = 8'h00;
  localparam logic [7:0] RST_CTRL2 = 8'h3f;
  localparam logic [7:0] RST_CTRL3 = 8'ha8;
  localparam logic [7:0] CMD_IDLE = 8'h55;
  localparam logic [7:0] CMD_ACK = 8'haa;
  // control field positions
  localparam int C1_OPER = 7;
  localparam int C1_PREC = 6;
  localparam int C1_NDE = 5;
  localparam int C1_RNG = 3;
  localparam int C1_TAP = 2;
  localparam int C1_MOT = 1;
  localparam int C1_TILT = 0;
  localparam int C2_REBOOT = 7;
  localparam int C2_CTEST = 6;
  localparam int C3_TILT_RATE = 6;
  localparam int C3_TAP_RATE = 3;
  localparam int C3_MOT_RATE = 0;
  // status bit positions
  localparam int ST_OPER = 7;
  localparam int ST_PREC = 6;
  localparam int ST_CRC = 5;
  localparam int ST_INT = 4;
  localparam int ST_POR = 3;
  localparam int ST_RUN = 2;
  localparam int ST_WAKE = 0;
  // sticky flag indices, also their bit in the source register except F_CRC, whose bit 3 carries the tap field there
  localparam int F_TILT = 0;
  localparam int F_WAKE = 1;
  localparam int F_NEW = 4;
  localparam int F_WM = 5;
  localparam int F_FULL = 6;
  localparam int F_SLEEP = 7;
  localparam int F_CRC = 3;
  localparam int NFLAG = 8;
  localparam int IS_TAP = 2;
  // buffer mode code for trigger mode
  localparam logic [1:0] BUF_MODE_TRIG = 2'h2;
  // low-power settle: 1.2/odr at the slowest odr of 0.781 hz
  localparam int CLK_PERIOD_NS = 100;
  localparam int SETTLE_TIME_US = 1536492;
  localparam int SETTLE_CYCLES = (SETTLE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // host register access, one byte per request
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } acr_req_t;
  // events from the sensing engines and buffer, same clock
  typedef struct packed {
    logic sample_new;
    logic sleep_evt;
    logic wake_evt;
    logic [5:0] wake_dir;
    logic tilt_evt;
    logic [5:0] tilt_dir;
    logic tap_evt;
    logic [1:0] tap_kind;
    logic buf_full;
    logic buf_read;
    logic [7:0] buf_level;
    logic [6:0] watermark_level;
    logic [1:0] buf_mode;
    logic reboot_done;
  } acr_evt_t;
  // control outputs towards the core
  typedef struct packed {
    logic operate_enable;
    logic fine_precision_select;
    logic [1:0] range_select;
    logic new_sample_irq_enable;
    logic tap_engine_enable;
    logic motion_engine_enable;
    logic tilt_engine_enable;
    logic [1:0] tilt_rate;
    logic [2:0] tap_rate_field;
    logic [2:0] motion_rate_field;
    logic running;
    logic reboot_busy;
    logic irq_any;
    logic release_pulse;
  } acr_ctrl_t;
  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
  } acr_sync_t;
  typedef struct packed {
    logic q;
  } acr_flag_t;
endpackage : acr_pkg

// File: rtl/acr_regs.sv
// status, interrupt-source and control register bank
// assumes a serial front end hands over one byte read or write per cycle
`timescale 1ns/1ps
module acr_regs #(
  parameter int SETTLE_CYC = acr_pkg::SETTLE_CYCLES // low-power settle count
) (
  input wire logic mclk,
  input wire logic rst,
  input wire acr_pkg::acr_req_t req,
  input wire acr_pkg::acr_evt_t evt,
  input wire logic otp_fail_pin,
  input wire logic vdd_low_pin,
  output logic [7:0] rd_data,
  output logic i2c_nack,
  output acr_pkg::acr_ctrl_t ctrl
);
  // module state apart from the sticky flags and the synchroniser
  typedef struct packed {
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [7:0] ctrl3;
    logic [1:0] tap_kind_field;
    logic [5:0] axis;
    logic wake_state;
    logic por;
    logic [23:0] settle;
    logic [7:0] rd_data;
    acr_pkg::acr_ctrl_t out;
  } acr_state_t;

  acr_state_t st_r;
  acr_state_t st_nxt;
  localparam int IS_TAP_HI = acr_pkg::IS_TAP + 1; // top bit of the tap field
  logic [1:0] pins_s; // synchronised otp fail, supply low
  logic [acr_pkg::NFLAG-1:0] flag_q; // sticky flag outputs
  logic [acr_pkg::NFLAG-1:0] flag_set;
  logic [acr_pkg::NFLAG-1:0] flag_clr;
  logic rel_rd; // latch release read
  logic status_rd;
  logic cmd_rd;
  logic reboot_go;
  logic irq_now;

  // address window of the acceleration output bytes
  function automatic logic is_data(input logic [7:0] a);
    return (a >= acr_pkg::OFS_DATA_FIRST) && (a <= acr_pkg::OFS_DATA_LAST);
  endfunction : is_data

  // read strobe on one address
  function automatic logic rd_at(input acr_pkg::acr_req_t r, input logic [7:0] a);
    return r.rd && (r.addr == a);
  endfunction : rd_at

  acr_sync2 u_sync (
    .mclk(mclk),
    .rst(rst),
    .din({otp_fail_pin, vdd_low_pin}),
    .dout(pins_s)
  );

  // one sticky cell per flag; unused slots never set
  genvar gi;
  generate
    for (gi = 0; gi < acr_pkg::NFLAG; gi++) begin : g_flag
      acr_sticky u_flag (
        .mclk(mclk),
        .rst(rst),
        .set(flag_set[gi]),
        .clr(flag_clr[gi]),
        .q(flag_q[gi])
      );
    end
  endgenerate

  // access decode
  always_comb begin
    rel_rd = rd_at(req, acr_pkg::OFS_RELEASE);
    status_rd = rd_at(req, acr_pkg::OFS_STATUS);
    cmd_rd = rd_at(req, acr_pkg::OFS_CMD_RESP);
    // a reboot already running is not restarted
    reboot_go = req.wr && (req.addr == acr_pkg::OFS_CTRL2)
      && req.wdata[acr_pkg::C2_REBOOT] && !st_r.out.reboot_busy;
  end

  // flag set and clear terms
  always_comb begin
    logic oper;
    oper = st_r.ctrl1[acr_pkg::C1_OPER];
    flag_set = '0;
    flag_clr = '0;
    // back-to-sleep comes from the motion engine
    flag_set[acr_pkg::F_SLEEP] = evt.sleep_evt && oper
      && st_r.ctrl1[acr_pkg::C1_MOT];
    flag_clr[acr_pkg::F_SLEEP] = rel_rd;
    flag_set[acr_pkg::F_FULL] = evt.buf_full;
    flag_clr[acr_pkg::F_FULL] = evt.buf_read;
    // watermark unused in trigger mode
    flag_set[acr_pkg::F_WM] = (evt.buf_mode != acr_pkg::BUF_MODE_TRIG)
      && (evt.buf_level > {1'b0, evt.watermark_level});
    flag_clr[acr_pkg::F_WM] = evt.buf_read
      && (evt.buf_level <= {1'b0, evt.watermark_level});
    flag_set[acr_pkg::F_NEW] = evt.sample_new && oper;
    flag_clr[acr_pkg::F_NEW] = rel_rd || (req.rd && is_data(req.addr));
    flag_set[acr_pkg::F_WAKE] = evt.wake_evt && oper
      && st_r.ctrl1[acr_pkg::C1_MOT];
    flag_clr[acr_pkg::F_WAKE] = rel_rd;
    // masked directions never raise the tilt flag
    flag_set[acr_pkg::F_TILT] = evt.tilt_evt && oper
      && st_r.ctrl1[acr_pkg::C1_TILT]
      && |(evt.tilt_dir & st_r.ctrl2[5:0]);
    flag_clr[acr_pkg::F_TILT] = rel_rd;
    // a reboot is the documented way out of a load failure
    flag_set[acr_pkg::F_CRC] = pins_s[1];
    flag_clr[acr_pkg::F_CRC] = reboot_go;
  end

  // next state
  always_comb begin
    logic oper_n;
    logic [7:0] src;
    oper_n = 1'b0;
    src = 8'h00;
    st_nxt = st_r;
    st_nxt.out.release_pulse = rel_rd;
    // host writes; control changes are trusted to follow standby
    if (req.wr && !st_r.out.reboot_busy) begin
      case (req.addr)
        acr_pkg::OFS_CTRL1: st_nxt.ctrl1 = req.wdata;
        acr_pkg::OFS_CTRL2: st_nxt.ctrl2 = req.wdata;
        acr_pkg::OFS_CTRL3: st_nxt.ctrl3 = req.wdata;
        default: ;
      endcase
    end
    // test response read drops the trigger
    if (cmd_rd && st_r.ctrl2[acr_pkg::C2_CTEST]) begin
      st_nxt.ctrl2[acr_pkg::C2_CTEST] = 1'b0;
    end
    // reboot holds the bit at 1 and restores defaults on completion
    if (reboot_go) begin
      st_nxt.out.reboot_busy = 1'b1;
    end else if (st_r.out.reboot_busy && evt.reboot_done) begin
      st_nxt.out.reboot_busy = 1'b0;
      st_nxt.ctrl1 = acr_pkg::RST_CTRL1;
      st_nxt.ctrl2 = acr_pkg::RST_CTRL2;
      st_nxt.ctrl3 = acr_pkg::RST_CTRL3;
    end
    // tap kind latch, event wins over release
    if (evt.tap_evt && st_r.ctrl1[acr_pkg::C1_OPER] && st_r.ctrl1[acr_pkg::C1_TAP]) begin
      st_nxt.tap_kind_field = evt.tap_kind;
    end else if (rel_rd) begin
      st_nxt.tap_kind_field = 2'h0;
    end
    // direction that caused the motion flag
    if (flag_set[acr_pkg::F_WAKE]) begin
      st_nxt.axis = evt.wake_dir;
    end else if (rel_rd) begin
      st_nxt.axis = 6'h00;
    end
    // motion state only, power mode untouched
    if (flag_set[acr_pkg::F_WAKE]) begin
      st_nxt.wake_state = 1'b1;
    end else if (flag_set[acr_pkg::F_SLEEP]) begin
      st_nxt.wake_state = 1'b0;
    end
    if (status_rd) begin
      st_nxt.por = 1'b0;
    end
    // settle count runs after entering low-power operation
    oper_n = st_nxt.ctrl1[acr_pkg::C1_OPER];
    if (!oper_n) begin
      st_nxt.settle = '0;
    end else if (!st_r.ctrl1[acr_pkg::C1_OPER]) begin
      st_nxt.settle = st_nxt.ctrl1[acr_pkg::C1_PREC] ? 24'h000000
        : SETTLE_CYC[23:0];
    end else if (st_r.settle != 24'h000000) begin
      st_nxt.settle = st_r.settle - 24'h000001;
    end
    // combined interrupt from enabled sources
    st_nxt.out.irq_any = irq_now;
    // read data mux
    src = flag_q;
    src[IS_TAP_HI:acr_pkg::IS_TAP] = st_r.tap_kind_field;
    if (req.rd) begin
      case (req.addr)
        acr_pkg::OFS_CMD_RESP: begin
          st_nxt.rd_data = st_r.ctrl2[acr_pkg::C2_CTEST] ? acr_pkg::CMD_ACK
            : acr_pkg::CMD_IDLE;
        end
        acr_pkg::OFS_IRQ_SRC: st_nxt.rd_data = src;
        acr_pkg::OFS_AXIS: st_nxt.rd_data = {2'h0, st_r.axis};
        acr_pkg::OFS_STATUS: begin
          st_nxt.rd_data = 8'h00;
          st_nxt.rd_data[acr_pkg::ST_OPER] = st_r.ctrl1[acr_pkg::C1_OPER];
          st_nxt.rd_data[acr_pkg::ST_PREC] = st_r.ctrl1[acr_pkg::C1_PREC];
          st_nxt.rd_data[acr_pkg::ST_CRC] = flag_q[acr_pkg::F_CRC];
          st_nxt.rd_data[acr_pkg::ST_INT] = st_r.out.irq_any;
          st_nxt.rd_data[acr_pkg::ST_POR] = st_r.por;
          st_nxt.rd_data[acr_pkg::ST_RUN] = st_r.out.running;
          st_nxt.rd_data[acr_pkg::ST_WAKE] = st_r.wake_state;
        end
        acr_pkg::OFS_CTRL1: st_nxt.rd_data = st_r.ctrl1;
        acr_pkg::OFS_CTRL2: st_nxt.rd_data = st_r.ctrl2;
        acr_pkg::OFS_CTRL3: st_nxt.rd_data = st_r.ctrl3;
        default: st_nxt.rd_data = 8'h00; // release read is dummy
      endcase
    end
    // control outputs follow the registers they come from
    st_nxt.out.operate_enable = oper_n;
    st_nxt.out.fine_precision_select = st_nxt.ctrl1[acr_pkg::C1_PREC];
    st_nxt.out.range_select = st_nxt.ctrl1[acr_pkg::C1_RNG+:2];
    st_nxt.out.new_sample_irq_enable = st_nxt.ctrl1[acr_pkg::C1_NDE];
    st_nxt.out.tap_engine_enable = oper_n && st_nxt.ctrl1[acr_pkg::C1_TAP];
    st_nxt.out.motion_engine_enable = oper_n && st_nxt.ctrl1[acr_pkg::C1_MOT];
    st_nxt.out.tilt_engine_enable = oper_n && st_nxt.ctrl1[acr_pkg::C1_TILT];
    st_nxt.out.tilt_rate = st_nxt.ctrl3[acr_pkg::C3_TILT_RATE+:2];
    st_nxt.out.tap_rate_field = st_nxt.ctrl3[acr_pkg::C3_TAP_RATE+:3];
    st_nxt.out.motion_rate_field = st_nxt.ctrl3[acr_pkg::C3_MOT_RATE+:3];
    // supply low or standby reads as not sensing
    st_nxt.out.running = oper_n && (st_nxt.settle == 24'h000000)
      && !pins_s[0];
  end

  // interrupt or-tree; new-sample only counts when its enable is set
  always_comb begin
    irq_now = flag_q[acr_pkg::F_SLEEP] || flag_q[acr_pkg::F_FULL]
      || flag_q[acr_pkg::F_WM] || flag_q[acr_pkg::F_WAKE]
      || flag_q[acr_pkg::F_TILT] || (st_r.tap_kind_field != 2'h0)
      || (flag_q[acr_pkg::F_NEW] && st_r.ctrl1[acr_pkg::C1_NDE]);
  end

  // state register
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= '0;
      st_r.ctrl1 <= acr_pkg::RST_CTRL1;
      st_r.ctrl2 <= acr_pkg::RST_CTRL2;
      st_r.ctrl3 <= acr_pkg::RST_CTRL3;
      st_r.por <= 1'b1;
      st_r.out.tilt_rate <= acr_pkg::RST_CTRL3[7:6];
      st_r.out.tap_rate_field <= acr_pkg::RST_CTRL3[5:3];
      st_r.out.motion_rate_field <= acr_pkg::RST_CTRL3[2:0];
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_data = st_r.rd_data;
  assign i2c_nack = st_r.out.reboot_busy;
  assign ctrl = st_r.out;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  AST_REL_CLEARS: assert property (
    (rel_rd && !flag_set[acr_pkg::F_WAKE] && !flag_set[acr_pkg::F_SLEEP])
      |=> !flag_q[acr_pkg::F_WAKE] && !flag_q[acr_pkg::F_SLEEP] && st_r.axis == 6'h00)
    else $error("release read left a latch set");
  AST_AXIS_TOP: assert property (
    rd_at(req, acr_pkg::OFS_AXIS) |=> rd_data[7:6] == 2'h0)
    else $error("axis report top bits not zero");
  AST_MIRROR: assert property (
    status_rd |=> rd_data[7:6] == $past(st_r.ctrl1[7:6]))
    else $error("status does not mirror control bits");
  AST_POR: assert property (
    status_rd |=> !st_r.por ##1 (!rd_data[acr_pkg::ST_POR] || !$past(status_rd)))
    else $error("power-on bit not cleared by status read");
  AST_CMD: assert property (
    (cmd_rd && st_r.ctrl2[acr_pkg::C2_CTEST])
      |=> rd_data == acr_pkg::CMD_ACK && !st_r.ctrl2[acr_pkg::C2_CTEST])
    else $error("command test handshake wrong");
  AST_RANGE: assert property (
    ctrl.range_select == st_r.ctrl1[acr_pkg::C1_RNG+:2])
    else $error("range select does not follow control");
  AST_MASK: assert property (
    (evt.tilt_evt && (evt.tilt_dir & st_r.ctrl2[5:0]) == 6'h00
      && !flag_q[acr_pkg::F_TILT]) |=> !flag_q[acr_pkg::F_TILT])
    else $error("masked tilt raised the flag");
  AST_REBOOT: assert property (
    reboot_go |=> i2c_nack && st_r.ctrl2[acr_pkg::C2_REBOOT])
    else $error("reboot not reported busy");
  // a latched wake, tilt, sleep or buffer-full flag must show in the combined bit next cycle
  AST_INT: assert property (
    (flag_q[acr_pkg::F_WAKE] || flag_q[acr_pkg::F_TILT] || flag_q[acr_pkg::F_SLEEP]
      || flag_q[acr_pkg::F_FULL]) |=> ctrl.irq_any)
    else $error("combined interrupt wrong");
  AST_WM_TRIG: assert property (
    (evt.buf_mode == acr_pkg::BUF_MODE_TRIG && !flag_q[acr_pkg::F_WM])
      |=> !flag_q[acr_pkg::F_WM])
    else $error("watermark raised in trigger mode");
  // pin release is a single-cycle pulse per release read
  AST_REL_PULSE: assert property (
    rel_rd |=> ctrl.release_pulse)
    else $error("release read gave no pin release pulse");
  AST_REL_QUIET: assert property (
    !rel_rd |=> !ctrl.release_pulse)
    else $error("pin release pulse without release read");
  // writes during the reboot must not land
  AST_WR_REFUSED: assert property (
    (i2c_nack && req.wr && req.addr == acr_pkg::OFS_CTRL3 && !evt.reboot_done)
      |=> $stable(st_r.ctrl3))
    else $error("write accepted during reboot");
  AST_REBOOT_END: assert property (
    (i2c_nack && evt.reboot_done)
      |=> !i2c_nack && st_r.ctrl2 == acr_pkg::RST_CTRL2)
    else $error("reboot did not finish cleanly");
  // engines stay off in standby whatever their enable bits say
  AST_STANDBY_ENG: assert property (
    !ctrl.operate_enable |-> !ctrl.tap_engine_enable && !ctrl.motion_engine_enable
      && !ctrl.tilt_engine_enable)
    else $error("engine enabled in standby");
  AST_NEW_CLR: assert property (
    (req.rd && is_data(req.addr) && !flag_set[acr_pkg::F_NEW])
      |=> !flag_q[acr_pkg::F_NEW])
    else $error("data read left new-sample flag set");
  AST_RUN_LOW: assert property (
    pins_s[0] |=> !ctrl.running)
    else $error("running reported with supply low");
endmodule : acr_regs

// File: rtl/acr_sticky.sv
// one sticky status flag
// assumes set and clear come from logic on mclk
`timescale 1ns/1ps
module acr_sticky (
  input wire logic mclk,
  input wire logic rst,
  input wire logic set,
  input wire logic clr,
  output logic q
);
  acr_pkg::acr_flag_t st_r;
  acr_pkg::acr_flag_t st_nxt;
  // set beats clear so a same-cycle event is kept
  always_comb begin
    st_nxt = st_r;
    if (set) begin
      st_nxt.q = 1'b1;
    end else if (clr) begin
      st_nxt.q = 1'b0;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign q = st_r.q;
endmodule : acr_sticky

// File: rtl/acr_sync2.sv
// two-flop synchroniser for the two pin levels
// assumes inputs are asynchronous to mclk
`timescale 1ns/1ps
module acr_sync2 (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [1:0] din,
  output logic [1:0] dout
);
  acr_pkg::acr_sync_t st_r; // both stages
  acr_pkg::acr_sync_t st_nxt;
  // first stage feeds only the second
  always_comb begin
    st_nxt.s1 = din;
    st_nxt.s2 = st_r.s1;
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign dout = st_r.s2;
endmodule : acr_sync2
